// >>> ipp_defs.svh
`ifndef IPP_DEFS_SVH
`define IPP_DEFS_SVH

// ----------------------------------------
// Widths, stage count, FIFO depth and reset values
// ----------------------------------------
`define IPP_WORD_W 16
`define IPP_LONG_W 32
`define IPP_STAGES 3
`define IPP_FIFO_DEPTH 4
`define IPP_RST_WORD 16'h0000
`define IPP_RST_LONG 32'h0000_0000
`define IPP_RST_ADDR 31'h0000_0000

`endif

// >>> ipp_pkg.sv
`include "ipp_defs.svh"

package ipp_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // One pipe stage: word, valid, abnormal-termination flag
  typedef struct packed {
    logic [15:0] word;
    logic valid;
    logic fault;
  } ipp_stage_t;

  // Prefetch request from the sequencer; address is in long-word units plus odd bit
  typedef struct packed {
    logic [30:0] longAddr;
    logic oddWord;
  } ipp_req_t;

  // Long word returned by cache or bus, with fault flag
  typedef struct packed {
    logic [31:0] data;
    logic fault;
  } ipp_fill_t;

  typedef enum logic [1:0] {
    IPP_IDLE,
    IPP_WAIT
  } ipp_fsm_t;

endpackage

// >>> ipp_fifo.sv
`timescale 1ns/1ps

// ----------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ----------------------------------------
module ipp_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_q;
  fifo_state_t st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWrite;
  logic doRead;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("ipp_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  assign inReady = (st_q.count != DEPTH[AW:0]);
  assign outValid = (st_q.count != '0);
  assign outData = mem[st_q.rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Pointer and count update
  always_comb begin
    st_d = st_q;
    if (doWrite) begin
      st_d.wrPtr = st_q.wrPtr + 1'b1;
    end
    if (doRead) begin
      st_d.rdPtr = st_q.rdPtr + 1'b1;
    end
    if (doWrite && !doRead) begin
      st_d.count = st_q.count + 1'b1;
    end else if (doRead && !doWrite) begin
      st_d.count = st_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[st_q.wrPtr] <= inData;
    end
  end
endmodule

// >>> ipp_prefetch_pipe.sv
`timescale 1ns/1ps
`include "ipp_defs.svh"

module ipp_prefetch_pipe
  import ipp_pkg::*;
#(
  parameter int FIFO_DEPTH = `IPP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  // Sequencer side
  input wire logic reqValid,
  input wire ipp_req_t req,
  input wire logic icacheEnable,
  input wire logic consumeD,
  input wire logic flushPipe,
  input wire logic [2:0] invalidateStage,
  output logic reqBusy,
  output ipp_stage_t stageB,
  output ipp_stage_t stageC,
  output ipp_stage_t stageD,
  output logic decodedValid,
  output logic [15:0] decodedWord,
  output logic decodedFault,
  // Instruction cache side
  output logic icacheLookup,
  output ipp_req_t icacheReq,
  input wire logic icacheHit,
  input wire ipp_fill_t icacheFill,
  // Bus controller side
  output logic busStart,
  output ipp_req_t busReq,
  output logic busAbort,
  input wire logic busDone,
  input wire ipp_fill_t busFill
);
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("ipp_prefetch_pipe: FIFO_DEPTH must be at least 2");
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ipp_fsm_t fsm;
    logic [31:0] holdData;
    logic holdFault;
    logic holdValid;
    logic [30:0] holdAddr;
    logic oddPending;
    ipp_stage_t b;
    ipp_stage_t c;
    ipp_stage_t d;
    logic icacheLookup;
    ipp_req_t icacheReq;
    logic busStart;
    ipp_req_t busReq;
    logic busAbort;
    logic reqBusy;
  } ipp_state_t;

  ipp_state_t st_q;
  ipp_state_t st_d;

  // Words headed for stage B pass through the FIFO
  logic [16:0] fifoInData;
  logic fifoInValid;
  logic fifoInReady;
  logic [16:0] fifoOutData;
  logic fifoOutValid;
  logic fifoOutReady;

  // Compare request against holding register
  function automatic logic holdHit(input ipp_req_t r, input logic hv, input logic [30:0] ha);
    holdHit = hv && (r.longAddr == ha);
  endfunction

  // Pick high or low half of a long word
  function automatic logic [15:0] pickHalf(input logic [31:0] lw, input logic odd);
    pickHalf = odd ? lw[15:0] : lw[31:16];
  endfunction

  ipp_fifo #(
    .WIDTH(17),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inData(fifoInData),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic fillArrive;
  ipp_fill_t fillNow;
  logic hitNow;
  logic vacD;
  logic vacC;
  logic moveCD;
  logic moveBC;
  logic loadB;

  always_comb begin
    st_d = st_q;
    fifoInData = '0;
    fifoInValid = 1'b0;
    fillNow = '0;
    fillArrive = 1'b0;
    // One-cycle strobes drop by default
    st_d.icacheLookup = 1'b0;
    st_d.busStart = 1'b0;
    st_d.busAbort = 1'b0;

    hitNow = holdHit(req, st_q.holdValid, st_q.holdAddr);

    vacD = consumeD && st_q.d.valid;
    // advance only into empty or vacating stage
    moveCD = st_q.c.valid && (!st_q.d.valid || vacD);
    vacC = moveCD;
    moveBC = st_q.b.valid && (!st_q.c.valid || vacC);
    loadB = fifoOutValid && (!st_q.b.valid || moveBC);
    fifoOutReady = loadB && !flushPipe;

    // shift B to C to D
    if (vacD) begin
      st_d.d.valid = 1'b0;
    end
    if (moveCD) begin
      st_d.d = st_q.c;
      st_d.c.valid = 1'b0;
    end
    if (moveBC) begin
      st_d.c = st_q.b;
      st_d.b.valid = 1'b0;
    end
    if (loadB) begin
      st_d.b.word = fifoOutData[16:1];
      st_d.b.fault = fifoOutData[0];
      st_d.b.valid = 1'b1;
    end

    if (invalidateStage[0]) begin
      st_d.b.valid = 1'b0;
    end
    if (invalidateStage[1]) begin
      st_d.c.valid = 1'b0;
    end
    if (invalidateStage[2]) begin
      st_d.d.valid = 1'b0;
    end

    unique case (st_q.fsm)
      IPP_IDLE: begin
        if (reqValid && fifoInReady && !flushPipe) begin
          // present to all three at once
          st_d.icacheLookup = icacheEnable;
          st_d.icacheReq = req;
          st_d.busStart = 1'b1;
          st_d.busReq = req;
          if (hitNow) begin
            // abort the bus cycle just issued
            st_d.busAbort = 1'b1;
            fifoInData = {pickHalf(st_q.holdData, req.oddWord), st_q.holdFault};
            fifoInValid = 1'b1;
          end else begin
            st_d.fsm = IPP_WAIT;
            st_d.reqBusy = 1'b1;
            st_d.oddPending = req.oddWord;
            st_d.holdAddr = req.longAddr;
            st_d.holdValid = 1'b0;
          end
        end
      end
      IPP_WAIT: begin
        if (icacheHit && st_q.icacheLookup) begin
          fillNow = icacheFill;
          fillArrive = 1'b1;
        end else if (busDone) begin
          fillNow = busFill;
          fillArrive = 1'b1;
        end
        if (fillArrive) begin
          st_d.holdData = fillNow.data;
          st_d.holdFault = fillNow.fault;
          st_d.holdValid = 1'b1;
          // even request gives high half to B
          fifoInData = {pickHalf(fillNow.data, st_q.oddPending), fillNow.fault};
          fifoInValid = 1'b1;
          st_d.fsm = IPP_IDLE;
          st_d.reqBusy = 1'b0;
          if (icacheHit && st_q.icacheLookup) begin
            st_d.busAbort = 1'b1;
          end
        end
      end
    endcase

    // Flush empties stages; holding register stays for reuse
    if (flushPipe) begin
      st_d.b.valid = 1'b0;
      st_d.c.valid = 1'b0;
      st_d.d.valid = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.fsm <= IPP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign reqBusy = st_q.reqBusy;
  assign stageB = st_q.b;
  assign stageC = st_q.c;
  assign stageD = st_q.d;
  assign decodedValid = st_q.d.valid;
  assign decodedWord = st_q.d.word;
  assign decodedFault = st_q.d.fault;
  assign icacheLookup = st_q.icacheLookup;
  assign icacheReq = st_q.icacheReq;
  assign busStart = st_q.busStart;
  assign busReq = st_q.busReq;
  assign busAbort = st_q.busAbort;
endmodule

// >>> ipp_prefetch_pipe_asserts.sv
`timescale 1ns/1ps
module ipp_prefetch_pipe_asserts
  import ipp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic icacheEnable,
  input wire logic consumeD,
  input wire logic flushPipe,
  input wire logic [2:0] invalidateStage,
  input wire logic reqBusy,
  input wire ipp_stage_t stageB,
  input wire ipp_stage_t stageC,
  input wire ipp_stage_t stageD,
  input wire logic decodedValid,
  input wire logic [15:0] decodedWord,
  input wire logic icacheLookup,
  input wire logic icacheHit,
  input wire logic busStart,
  input wire logic busAbort,
  input wire logic busDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus fill arrival while waiting, and no stage disturbance
  sequence s_fill;
    reqBusy && busDone;
  endsequence
  sequence s_quiet;
    !consumeD && !flushPipe && invalidateStage == 3'h0;
  endsequence
  a_start_cause:
    assert property (busStart |-> $past(reqValid)) else $error("start without request");
  a_lookup_pair:
    assert property (icacheLookup |-> busStart && $past(icacheEnable))
      else $error("lookup not paired with bus start");
  a_abort_cause:
    assert property (busAbort |-> busStart || $past(icacheHit)) else $error("stray abort");
  a_busy_hold:
    assert property (reqBusy && !icacheHit && !busDone |=> reqBusy) else $error("busy dropped");
  a_fill_release:
    assert property (s_fill |=> !reqBusy) else $error("busy kept after fill");
  a_c_from_b:
    assert property ($rose(stageC.valid) |-> $past(stageB.valid)
      && stageC.word == $past(stageB.word) && stageC.fault == $past(stageB.fault))
      else $error("stage C not loaded from B");
  a_d_from_c:
    assert property ($rose(stageD.valid) |-> $past(stageC.valid)
      && stageD.word == $past(stageC.word)) else $error("stage D not loaded from C");
  a_decode_copy:
    assert property (decodedValid == stageD.valid && (!decodedValid || decodedWord == stageD.word))
      else $error("decoded word not from stage D");
  a_c_holds:
    assert property (((stageC.valid && stageD.valid) and s_quiet) |=> $stable(stageC))
      else $error("stage C moved into full D");
endmodule

bind ipp_prefetch_pipe ipp_prefetch_pipe_asserts i_ipp_prefetch_pipe_asserts (.clk, .rst,
  .reqValid, .icacheEnable, .consumeD, .flushPipe, .invalidateStage, .reqBusy, .stageB,
  .stageC, .stageD, .decodedValid, .decodedWord, .icacheLookup, .icacheHit, .busStart,
  .busAbort, .busDone);

// >>> ipp_far_model.sv
`timescale 1ns/1ps
module ipp_far_model
  import ipp_pkg::*;
#(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic icacheLookup,
  input wire logic busStart,
  input wire logic busAbort,
  input wire ipp_req_t busReq,
  input wire logic hitOn,
  input wire logic faultOn,
  output logic icacheHit,
  output ipp_fill_t icacheFill,
  output logic busDone,
  output ipp_fill_t busFill
);
  logic [3:0] cnt;
  logic [30:0] addr;
  logic [32:0] cacheWord;
  // Cache answers in the lookup cycle itself; outside it the fill shows the inverse
  assign cacheWord = {4'hA, busReq.longAddr[11:0], 4'h5, busReq.longAddr[11:0], faultOn};
  assign icacheHit = icacheLookup && hitOn;
  assign icacheFill = icacheLookup ? cacheWord : ~cacheWord;
  // Bus answers LAT cycles after an unaborted start; idle data toggles every cycle
  always_ff @(posedge clk) begin
    busDone <= 1'h0;
    busFill <= ~busFill;
    if (rst) begin
      cnt <= 4'h0;
      busFill <= '0;
    end else if (busAbort) begin
      cnt <= 4'h0;
    end else if (busStart) begin
      cnt <= 4'(LAT);
      addr <= busReq.longAddr;
    end else if (cnt == 4'h1) begin
      cnt <= 4'h0;
      busDone <= 1'h1;
      busFill <= {4'hA, addr[11:0], 4'h5, addr[11:0], faultOn};
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import ipp_pkg::*;
  logic clk, rst, reqValid, icacheEnable, consumeD, flushPipe, reqBusy, hitOn, faultOn;
  logic [2:0] invalidateStage;
  ipp_req_t req, icacheReq, busReq;
  ipp_stage_t stageB, stageC, stageD;
  logic decodedValid, decodedFault, icacheLookup, icacheHit, busStart, busAbort, busDone;
  logic [15:0] decodedWord;
  ipp_fill_t icacheFill, busFill;
  int n_mismatch, comparisons, nAbort, nStart;
  ipp_prefetch_pipe #(.FIFO_DEPTH(4)) i_ipp_prefetch_pipe (.clk, .rst, .reqValid, .req,
    .icacheEnable, .consumeD, .flushPipe, .invalidateStage, .reqBusy, .stageB, .stageC,
    .stageD, .decodedValid, .decodedWord, .decodedFault, .icacheLookup, .icacheReq,
    .icacheHit, .icacheFill, .busStart, .busReq, .busAbort, .busDone, .busFill);
  ipp_far_model i_ipp_far_model (.clk, .rst, .icacheLookup, .busStart, .busAbort, .busReq,
    .hitOn, .faultOn, .icacheHit, .icacheFill, .busDone, .busFill);
  // Clock and strobe counters
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    nAbort += int'(busAbort === 1'h1);
    nStart += int'(busStart === 1'h1);
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic fetch(input logic [30:0] a, input logic odd);
    int n;
    n = 0;
    tick(1);
    while (reqBusy !== 1'h0) begin
      tick(1);
      n++;
      if (n > 60) begin
        n_mismatch++;
        complete_run();
      end
    end
    req = '{a, odd};
    reqValid = 1'h1;
    tick(1);
    reqValid = 1'h0;
  endtask
  task automatic pop(input logic [15:0] w, input logic f);
    int n;
    n = 0;
    tick(1);
    while (stageD.valid !== 1'h1) begin
      tick(1);
      n++;
      if (n > 60) begin
        n_mismatch++;
        complete_run();
      end
    end
    check({stageD.word, stageD.fault}, {w, f}, "stage D word");
    check({decodedWord, decodedFault}, {w, f}, "decoded word");
    check(17'(decodedValid), 17'h1, "decoded valid");
    consumeD = 1'h1;
    tick(1);
    consumeD = 1'h0;
  endtask
  task automatic t_pair(input logic cache, input logic [11:0] a, input int aborts);
    int a0;
    a0 = nAbort;
    icacheEnable = cache;
    hitOn = cache;
    fetch({19'h0_0000, a}, 1'h0);
    fetch({19'h0_0000, a}, 1'h1);
    check(17'({busReq, icacheReq} === {2{19'h0_0000, a, 1'h1}}), 17'h1, "request copies");
    pop({4'hA, a}, 1'h0);
    pop({4'h5, a}, 1'h0);
    check(17'(nAbort - a0), 17'(aborts), "abort count");
    $display("t_pair done");
  endtask
  task automatic t_fault_idle;
    int s;
    faultOn = 1'h1;
    fetch(31'h0000_0030, 1'h0);
    pop(16'hA030, 1'h1);
    faultOn = 1'h0;
    s = nStart;
    tick(12);
    check(17'(nStart - s), 17'h0, "no bus start");
    check({14'h0, stageB.valid, stageC.valid, stageD.valid}, 17'h0, "stages empty");
    $display("t_fault_idle done");
  endtask
  task automatic t_fill_drain;
    int s;
    for (int i = 0; i < 7; i++) fetch(31'(12'h040 + i / 2), 1'(i % 2));
    tick(8);
    s = nStart;
    fetch(31'h0000_0043, 1'h1);
    tick(4);
    check(17'(nStart - s), 17'h0, "full buffer refusal");
    check({14'h0, stageB.valid, stageC.valid, stageD.valid}, 17'h7, "three full");
    for (int i = 0; i < 7; i++) pop({(i % 2) ? 4'h5 : 4'hA, 12'(12'h040 + i / 2)}, 1'h0);
    $display("t_fill_drain done");
  endtask
  task automatic t_invalidate;
    fetch(31'h0000_0050, 1'h0);
    fetch(31'h0000_0050, 1'h1);
    tick(8);
    invalidateStage = 3'h4;
    tick(1);
    invalidateStage = 3'h0;
    check({15'h0, stageD.valid, stageC.valid}, 17'h1, "stage D dropped");
    flushPipe = 1'h1;
    tick(1);
    flushPipe = 1'h0;
    check({14'h0, stageB.valid, stageC.valid, stageD.valid}, 17'h0, "flushed");
    $display("t_invalidate done");
  endtask
  // Reset, then the scenarios
  initial begin
    rst = 1'h1;
    {reqValid, icacheEnable, consumeD, flushPipe, hitOn, faultOn} = 6'h00;
    invalidateStage = 3'h0;
    req = '0;
    tick(6);
    rst = 1'h0;
    t_pair(1'h0, 12'h010, 1);
    t_pair(1'h1, 12'h020, 2);
    t_fault_idle();
    icacheEnable = 1'h0;
    t_fill_drain();
    t_invalidate();
    complete_run();
  end
endmodule
